// ### verilog/lja_consts.vh
// Constants for the line jitter attenuator: map, fields, resets, timing
`ifndef LJA_CONSTS_VH
`define LJA_CONSTS_VH
`define LJA_ADDR_W          8
`define LJA_CTRL_OFFS       8'h00
`define LJA_STAT_OFFS       8'h04
`define LJA_CTRL_PATH_BIT   0
`define LJA_CTRL_DEEP_BIT   2
`define LJA_CTRL_CORNER_BIT 3
`define LJA_CTRL_LEN_LSB    4
`define LJA_CTRL_RESET      7'h00
`define LJA_LEN_E1_CODE     3'h0
`define LJA_RESP_OKAY       2'h0
`define LJA_RESP_SLVERR     2'h2
`define LJA_CLK_HZ          40000000
`define LJA_E1_HZ           2048000
`define LJA_T1_HZ           1544000
`define LJA_SUBSTEPS        8
`define LJA_ACC_BITS        16
`define LJA_DEPTH_SHALLOW   7'h20
`define LJA_DEPTH_DEEP      7'h40
`define LJA_MARGIN          7'h02
`define LJA_TRIM_SHIFT_BASE 4'h6
`define LJA_TRIM_LIMIT      16'h0800
`endif

// ### verilog/lja_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lja_sync #(
	parameter WIDTH = 11
) (
	input  wire             clk_i,
	input  wire             sys_rst_i,
	input  wire [WIDTH-1:0] async_i,
	output wire [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_r <= {WIDTH{1'b0}};
			sync_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;
endmodule // lja_sync

// ### verilog/lja_fifo.v
// Elastic two-bit symbol FIFO, 32 or 64 entries, preset to half full
`timescale 1ns/1ps
`include "lja_consts.vh"
module lja_fifo (
	input  wire       clk_i,
	input  wire       sys_rst_i,
	input  wire       init_i,
	input  wire       deep_i,
	input  wire       wr_en_i,
	input  wire [1:0] wr_data_i,
	input  wire       rd_en_i,
	output wire [1:0] rd_data_o,
	output wire [6:0] count_o
);
	reg  [1:0] mem_r [0:63];
	reg  [5:0] wr_ptr_r;
	reg  [5:0] rd_ptr_r;
	reg  [6:0] count_r;
	reg  [1:0] rd_data_r;
	wire [6:0] depth_w;
	wire [5:0] mask_w;
	wire       do_wr_w;
	wire       do_rd_w;
	integer    i;

	assign depth_w = deep_i ? `LJA_DEPTH_DEEP : `LJA_DEPTH_SHALLOW;
	assign mask_w  = deep_i ? 6'h3f : 6'h1f;
	assign do_wr_w = wr_en_i && (count_r < depth_w);
	assign do_rd_w = rd_en_i && (count_r != 7'h00);

	always @(posedge clk_i) begin
		if (sys_rst_i || init_i) begin
			// Half full gives the nominal throughput delay
			wr_ptr_r  <= depth_w[6:1];
			rd_ptr_r  <= 6'h00;
			count_r   <= {1'b0, depth_w[6:1]};
			rd_data_r <= 2'h0;
			for (i = 0; i < 64; i = i + 1) begin
				mem_r[i] <= 2'h0;
			end
		end else begin
			if (do_wr_w) begin
				mem_r[wr_ptr_r] <= wr_data_i;
				wr_ptr_r        <= (wr_ptr_r + 6'h01) & mask_w;
			end
			if (do_rd_w) begin
				rd_data_r <= mem_r[rd_ptr_r];
				rd_ptr_r  <= (rd_ptr_r + 6'h01) & mask_w;
			end
			if (do_wr_w && !do_rd_w) begin
				count_r <= count_r + 7'h01;
			end else if (do_rd_w && !do_wr_w) begin
				count_r <= count_r - 7'h01;
			end
		end
	end

	assign rd_data_o = rd_data_r;
	assign count_o   = count_r;
endmodule // lja_fifo

// ### verilog/lja_top.v
// Line jitter attenuator with AXI4-Lite control and status
//
// Function
// - Write on incoming clock, read on smoothed clock
// - Near full or empty: shift clock one eighth
// - Latency 16 bits shallow, 32 bits deep
// - Host mode: control bit picks rx or tx path
// - Host mode: control bit picks 32 or 64
// - Host mode: corner from depth and corner bit
// - Hardware mode: path pin picks rx or tx
// - Hardware mode: depth always 64 entries
// - Hardware mode: corner 3.5 Hz E1, 6 Hz T1
// - Smoothed clock from reference, no crystal
// - Line length zero is E1, else T1
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "lja_consts.vh"
module lja_top (
	input  wire        clk_i,
	input  wire        sys_rst_i,
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output wire [1:0]  s_axi_bresp_o,
	output wire        s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output wire        s_axi_arready_o,
	output wire [31:0] s_axi_rdata_o,
	output wire [1:0]  s_axi_rresp_o,
	output wire        s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	input  wire        mode_select_i,
	input  wire        jitter_path_select_i,
	input  wire [2:0]  line_length_select_i,
	input  wire        incoming_rx_clock_i,
	input  wire        rx_positive_data_i,
	input  wire        rx_negative_data_i,
	input  wire        incoming_tx_clock_i,
	input  wire        tx_positive_data_i,
	input  wire        tx_negative_data_i,
	output wire        smoothed_rx_clock_o,
	output wire        rx_positive_out_o,
	output wire        rx_negative_out_o,
	output wire        smoothed_tx_clock_o,
	output wire        tx_positive_out_o,
	output wire        tx_negative_out_o
);
	localparam [63:0] E1_STEP_W = (64'd`LJA_E1_HZ * 64'd`LJA_SUBSTEPS
		* 64'd65536) / 64'd`LJA_CLK_HZ;
	localparam [63:0] T1_STEP_W = (64'd`LJA_T1_HZ * 64'd`LJA_SUBSTEPS
		* 64'd65536) / 64'd`LJA_CLK_HZ;

	// Synchronised pins
	wire [10:0] pin_async_w;
	wire [10:0] pin_sync_w;
	wire        rx_clk_s_w;
	wire [1:0]  rx_dat_s_w;
	wire        tx_clk_s_w;
	wire [1:0]  tx_dat_s_w;
	wire        mode_s_w;
	wire        path_pin_s_w;
	wire [2:0]  len_pin_s_w;

	// Register bus state
	reg         awready_r;
	reg         wready_r;
	reg         aw_held_r;
	reg         w_held_r;
	reg  [7:0]  awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;
	reg         bvalid_r;
	reg  [1:0]  bresp_r;
	reg         arready_r;
	reg         rvalid_r;
	reg  [31:0] rdata_r;
	reg  [1:0]  rresp_r;
	reg  [6:0]  ctrl_r;

	// Effective configuration
	wire        hw_mode_w;
	wire        path_tx_w;
	wire        deep_w;
	wire [2:0]  len_w;
	wire        e1_w;
	wire        corner_w;
	reg  [1:0]  cfg_prev_r;
	wire        reinit_w;

	// Write side
	reg         rx_clk_d_r;
	reg         tx_clk_d_r;
	wire        wr_en_w;
	wire [1:0]  wr_data_w;

	// Smoothed clock generator
	reg  [15:0] acc_r;
	reg  [2:0]  sub_r;
	reg  [2:0]  sub_nxt;
	reg  signed [15:0] trim_r;
	reg  signed [15:0] trim_nxt;
	wire [16:0] step_sum_w;
	wire [15:0] step_w;
	wire [16:0] acc_sum_w;
	wire        tick_w;
	wire [6:0]  depth_w;
	wire [6:0]  count_w;
	wire        near_full_w;
	wire        near_empty_w;
	reg         rd_en_r;
	reg         rd_en_nxt;
	reg         slip_fast_r;
	reg         slip_slow_r;
	wire signed [7:0]  fill_err_w;
	wire [3:0]  trim_shift_w;
	wire signed [15:0] trim_add_w;
	wire signed [23:0] trim_wide_w;
	wire [1:0]  rd_data_w;
	reg  [7:0]  fast_cnt_r;
	reg  [7:0]  slow_cnt_r;

	// Output flops
	reg         rx_clk_o_r;
	reg  [1:0]  rx_dat_o_r;
	reg         tx_clk_o_r;
	reg  [1:0]  tx_dat_o_r;

	assign pin_async_w = {line_length_select_i, jitter_path_select_i,
		mode_select_i, tx_negative_data_i, tx_positive_data_i,
		incoming_tx_clock_i, rx_negative_data_i, rx_positive_data_i,
		incoming_rx_clock_i};

	lja_sync #(
		.WIDTH(11)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (pin_async_w),
		.sync_o    (pin_sync_w)
	);

	assign rx_clk_s_w   = pin_sync_w[0];
	assign rx_dat_s_w   = pin_sync_w[2:1];
	assign tx_clk_s_w   = pin_sync_w[3];
	assign tx_dat_s_w   = pin_sync_w[5:4];
	assign mode_s_w     = pin_sync_w[6];
	assign path_pin_s_w = pin_sync_w[7];
	assign len_pin_s_w  = pin_sync_w[10:8];

	// Configuration source
	assign hw_mode_w = ~mode_s_w;
	assign path_tx_w = hw_mode_w ? path_pin_s_w
		: ctrl_r[`LJA_CTRL_PATH_BIT];
	assign deep_w    = hw_mode_w ? 1'b1
		: ctrl_r[`LJA_CTRL_DEEP_BIT];
	assign len_w     = hw_mode_w ? len_pin_s_w
		: ctrl_r[`LJA_CTRL_LEN_LSB+2:`LJA_CTRL_LEN_LSB];
	assign e1_w      = (len_w == `LJA_LEN_E1_CODE);
	assign corner_w  = hw_mode_w ? e1_w
		: ctrl_r[`LJA_CTRL_CORNER_BIT];
	assign depth_w   = deep_w ? `LJA_DEPTH_DEEP : `LJA_DEPTH_SHALLOW;

	// Depth or path change restarts the FIFO
	assign reinit_w = (cfg_prev_r != {path_tx_w, deep_w});

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_prev_r <= 2'h0;
			rx_clk_d_r <= 1'b0;
			tx_clk_d_r <= 1'b0;
		end else begin
			cfg_prev_r <= {path_tx_w, deep_w};
			rx_clk_d_r <= rx_clk_s_w;
			tx_clk_d_r <= tx_clk_s_w;
		end
	end

	// Symbols enter on the falling edge of the path's own clock
	assign wr_en_w   = path_tx_w ? (tx_clk_d_r & ~tx_clk_s_w)
		: (rx_clk_d_r & ~rx_clk_s_w);
	assign wr_data_w = path_tx_w ? tx_dat_s_w : rx_dat_s_w;

	lja_fifo u_fifo (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.init_i    (reinit_w),
		.deep_i    (deep_w),
		.wr_en_i   (wr_en_w),
		.wr_data_i (wr_data_w),
		.rd_en_i   (rd_en_r),
		.rd_data_o (rd_data_w),
		.count_o   (count_w)
	);

	// Reference-derived eighth-bit ticks with slow frequency trim
	assign step_sum_w = {1'b0, (e1_w ? E1_STEP_W[15:0] : T1_STEP_W[15:0])}
		+ {trim_r[15], trim_r};
	assign step_w     = step_sum_w[15:0];
	assign acc_sum_w  = {1'b0, acc_r} + {1'b0, step_w};
	assign tick_w     = acc_sum_w[16];

	assign near_full_w  = (count_w >= (depth_w - `LJA_MARGIN));
	assign near_empty_w = (count_w <= `LJA_MARGIN);

	// Lower corner: deeper FIFO and corner bit slow the trim loop
	assign fill_err_w   = $signed({1'b0, count_w})
		- $signed({2'b00, depth_w[6:1]});
	assign trim_shift_w = `LJA_TRIM_SHIFT_BASE + {3'h0, deep_w}
		+ {3'h0, corner_w};
	assign trim_wide_w  = $signed({{8{fill_err_w[7]}}, fill_err_w, 8'h00})
		>>> trim_shift_w;
	assign trim_add_w   = trim_wide_w[15:0];

	always @* begin
		sub_nxt   = sub_r;
		rd_en_nxt = 1'b0;
		trim_nxt  = trim_r;
		if (tick_w) begin
			if (sub_r == 3'h7) begin
				if (near_empty_w && !slip_slow_r) begin
					// Stretch this bit by one eighth
					sub_nxt = 3'h7;
				end else begin
					// Shorten the next bit by one eighth when near full
					sub_nxt   = near_full_w ? 3'h1 : 3'h0;
					rd_en_nxt = 1'b1;
					trim_nxt  = trim_r + trim_add_w;
					if (trim_nxt > $signed(`LJA_TRIM_LIMIT)) begin
						trim_nxt = $signed(`LJA_TRIM_LIMIT);
					end else if (trim_nxt < -$signed(`LJA_TRIM_LIMIT)) begin
						trim_nxt = -$signed(`LJA_TRIM_LIMIT);
					end
				end
			end else begin
				sub_nxt = sub_r + 3'h1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i || reinit_w) begin
			acc_r       <= 16'h0000;
			sub_r       <= 3'h0;
			trim_r      <= 16'sh0000;
			rd_en_r     <= 1'b0;
			slip_fast_r <= 1'b0;
			slip_slow_r <= 1'b0;
		end else begin
			acc_r   <= acc_sum_w[15:0];
			sub_r   <= sub_nxt;
			trim_r  <= trim_nxt;
			rd_en_r <= rd_en_nxt;
			if (tick_w && sub_r == 3'h7) begin
				slip_slow_r <= near_empty_w && !slip_slow_r;
				slip_fast_r <= near_full_w && !(near_empty_w && !slip_slow_r);
			end else begin
				slip_fast_r <= 1'b0;
			end
		end
	end

	// Saturating correction counters for status
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			fast_cnt_r <= 8'h00;
			slow_cnt_r <= 8'h00;
		end else if (tick_w && sub_r == 3'h7) begin
			if (near_empty_w && !slip_slow_r) begin
				slow_cnt_r <= slow_cnt_r + {7'h00, slow_cnt_r != 8'hff};
			end else if (near_full_w) begin
				fast_cnt_r <= fast_cnt_r + {7'h00, fast_cnt_r != 8'hff};
			end
		end
	end

	// Selected path takes the smoothed clock; the other passes through
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			rx_clk_o_r <= 1'b0;
			rx_dat_o_r <= 2'h0;
			tx_clk_o_r <= 1'b0;
			tx_dat_o_r <= 2'h0;
		end else if (path_tx_w) begin
			tx_clk_o_r <= (sub_r < 3'h4);
			tx_dat_o_r <= rd_data_w;
			rx_clk_o_r <= rx_clk_s_w;
			rx_dat_o_r <= rx_dat_s_w;
		end else begin
			rx_clk_o_r <= (sub_r < 3'h4);
			rx_dat_o_r <= rd_data_w;
			tx_clk_o_r <= tx_clk_s_w;
			tx_dat_o_r <= tx_dat_s_w;
		end
	end

	// AXI4-Lite write channel
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `LJA_RESP_OKAY;
			ctrl_r    <= `LJA_CTRL_RESET;
		end else begin
			if (s_axi_awvalid_i && awready_r) begin
				awready_r <= 1'b0;
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && wready_r) begin
				wready_r <= 1'b0;
				w_held_r <= 1'b1;
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
			end
			if (aw_held_r && w_held_r && !bvalid_r) begin
				bvalid_r  <= 1'b1;
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				if (awaddr_r == `LJA_CTRL_OFFS) begin
					bresp_r <= `LJA_RESP_OKAY;
					if (wstrb_r[0]) begin
						ctrl_r <= wdata_r[6:0];
					end
				end else if (awaddr_r == `LJA_STAT_OFFS) begin
					bresp_r <= `LJA_RESP_OKAY;
				end else begin
					bresp_r <= `LJA_RESP_SLVERR;
				end
			end
			if (bvalid_r && s_axi_bready_i) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `LJA_RESP_OKAY;
		end else if (s_axi_arvalid_i && arready_r) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b1;
			rresp_r   <= `LJA_RESP_OKAY;
			if (s_axi_araddr_i == `LJA_CTRL_OFFS) begin
				rdata_r <= {25'h0, ctrl_r};
			end else if (s_axi_araddr_i == `LJA_STAT_OFFS) begin
				rdata_r <= {slow_cnt_r, fast_cnt_r, 3'h0, e1_w, corner_w,
					deep_w, path_tx_w, hw_mode_w, 1'b0, count_w};
			end else begin
				rdata_r <= 32'h00000000;
				rresp_r <= `LJA_RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b1;
		end
	end

	assign s_axi_awready_o     = awready_r;
	assign s_axi_wready_o      = wready_r;
	assign s_axi_bresp_o       = bresp_r;
	assign s_axi_bvalid_o      = bvalid_r;
	assign s_axi_arready_o     = arready_r;
	assign s_axi_rdata_o       = rdata_r;
	assign s_axi_rresp_o       = rresp_r;
	assign s_axi_rvalid_o      = rvalid_r;
	assign smoothed_rx_clock_o = rx_clk_o_r;
	assign rx_positive_out_o   = rx_dat_o_r[0];
	assign rx_negative_out_o   = rx_dat_o_r[1];
	assign smoothed_tx_clock_o = tx_clk_o_r;
	assign tx_positive_out_o   = tx_dat_o_r[0];
	assign tx_negative_out_o   = tx_dat_o_r[1];
endmodule // lja_top

// ### testbench/lja_top_monitor.sv
// Port checker for the line jitter attenuator
`timescale 1ns/1ps
module lja_top_monitor (
	input wire        clk_i,
	input wire        sys_rst_i,
	input wire        s_axi_awvalid_i,
	input wire        s_axi_awready_o,
	input wire        s_axi_wvalid_i,
	input wire        s_axi_wready_o,
	input wire        s_axi_bvalid_o,
	input wire        s_axi_bready_i,
	input wire [1:0]  s_axi_bresp_o,
	input wire        s_axi_arvalid_i,
	input wire        s_axi_arready_o,
	input wire [7:0]  s_axi_araddr_i,
	input wire        s_axi_rvalid_o,
	input wire        s_axi_rready_i,
	input wire [31:0] s_axi_rdata_o,
	input wire [1:0]  s_axi_rresp_o,
	input wire        mode_select_i,
	input wire        jitter_path_select_i,
	input wire        incoming_rx_clock_i,
	input wire        incoming_tx_clock_i,
	input wire        tx_positive_data_i,
	input wire        smoothed_rx_clock_o,
	input wire        smoothed_tx_clock_o,
	input wire        rx_positive_out_o,
	input wire        tx_positive_out_o
);
	logic [3:0] hr_r;
	logic [3:0] ht_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Settled cycles in hardware mode on the rx path
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || mode_select_i || jitter_path_select_i)
			hr_r <= 4'h0;
		else if (hr_r != 4'hf)
			hr_r <= hr_r + 4'h1;
	end
	// Settled cycles in hardware mode on the tx path
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || mode_select_i || !jitter_path_select_i)
			ht_r <= 4'h0;
		else if (ht_r != 4'hf)
			ht_r <= ht_r + 4'h1;
	end
	bresp_hold_a: assert property (
		s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer dropped");
	write_answer_a: assert property (
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
		s_axi_wready_o |-> ##2 s_axi_bvalid_o && !s_axi_awready_o)
		else $error("write answer late");
	read_answer_a: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=>
		s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read answer late");
	unmapped_read_a: assert property (
		s_axi_arvalid_i && s_axi_arready_o &&
		s_axi_araddr_i[7:3] != 5'h00 |=>
		s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	tx_bypass_a: assert property (
		hr_r == 4'hf |->
		smoothed_tx_clock_o == $past(incoming_tx_clock_i, 3) &&
		tx_positive_out_o == $past(tx_positive_data_i, 3))
		else $error("idle tx path not passed through");
	rx_bypass_a: assert property (
		ht_r == 4'hf |->
		smoothed_rx_clock_o == $past(incoming_rx_clock_i, 3))
		else $error("idle rx path not passed through");
	clock_high_a: assert property (
		hr_r == 4'hf && $rose(smoothed_rx_clock_o) |->
		smoothed_rx_clock_o [*5])
		else $error("smoothed clock high too short");
	paced_data_a: assert property (
		hr_r == 4'hf && $changed(rx_positive_out_o) |->
		$past(smoothed_rx_clock_o) && !$past(smoothed_rx_clock_o, 2))
		else $error("output data off the smoothed clock");
endmodule // lja_top_monitor

bind lja_top lja_top_monitor u_mon (.*);

// ### testbench/lja_line_model.sv
// Framer-side source of line clock and symbol rails
`timescale 1ns/1ps
module lja_line_model (
	input  wire logic       run_i,
	input  wire logic [1:0] sym_i,
	input  int              half_i,
	output logic            clk_o,
	output logic            pos_o,
	output logic            neg_o
);
	initial begin
		clk_o = 1'b0;
		pos_o = 1'b0;
		neg_o = 1'b0;
		forever begin
			#(half_i);
			if (!run_i) begin
				clk_o = 1'b0;
				{neg_o, pos_o} = 2'h0;
			end else begin
				clk_o = ~clk_o;
				// New symbol at rise, steady at the sampling fall
				if (clk_o)
					{neg_o, pos_o} = sym_i;
			end
		end
	end
endmodule // lja_line_model

// ### testbench/testbench.sv
// Self-checking bench for the line jitter attenuator
`timescale 1ns/1ps
module testbench;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  s_axi_awaddr_i = 8'h00;
	logic        s_axi_awvalid_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_wvalid_i = 1'b0;
	logic        s_axi_bready_i = 1'b0;
	logic [7:0]  s_axi_araddr_i = 8'h00;
	logic        s_axi_arvalid_i = 1'b0;
	logic        s_axi_rready_i = 1'b0;
	logic        mode_select_i = 1'b1;
	logic        jitter_path_select_i = 1'b0;
	logic [2:0]  line_length_select_i = 3'h0;
	logic        run = 1'b0;
	logic [1:0]  sym = 2'h0;
	int          half = 244;
	logic        lclk;
	logic        lpos;
	logic        lneg;
	logic [31:0] rd_d;
	logic [1:0]  rsp;
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	wire         incoming_rx_clock_i = lclk;
	wire         rx_positive_data_i = lpos;
	wire         rx_negative_data_i = lneg;
	wire         incoming_tx_clock_i = lclk;
	wire         tx_positive_data_i = lpos;
	wire         tx_negative_data_i = lneg;
	wire         s_axi_awready_o;
	wire         s_axi_wready_o;
	wire         s_axi_bvalid_o;
	wire         s_axi_arready_o;
	wire         s_axi_rvalid_o;
	wire [1:0]   s_axi_bresp_o;
	wire [1:0]   s_axi_rresp_o;
	wire [31:0]  s_axi_rdata_o;
	wire         smoothed_rx_clock_o;
	wire         rx_positive_out_o;
	wire         rx_negative_out_o;
	wire         smoothed_tx_clock_o;
	wire         tx_positive_out_o;
	wire         tx_negative_out_o;

	lja_line_model u_src (
		.run_i (run),
		.sym_i (sym),
		.half_i(half),
		.clk_o (lclk),
		.pos_o (lpos),
		.neg_o (lneg)
	);
	lja_top dut (.*);

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("%0d compares, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: %h, expected %h", $time, s, e);
		end
	endtask

	task automatic rst();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end while (s_axi_bvalid_o !== 1'b1);
		// Answer must stand while ready is held back
		s_axi_bready_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
		rsp = s_axi_bresp_o;
		s_axi_bready_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end while (s_axi_rvalid_o !== 1'b1);
		s_axi_rready_i <= 1'b1;
		do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
		rd_d = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
		s_axi_rready_i <= 1'b0;
	endtask

	task automatic t_reg();
		rd(8'h00);
		chk(rd_d, 32'h0);
		rd(8'h04);
		chk(rd_d[12:8], 5'h10);
		chk(rd_d[6:0] - 7'h0e < 7'h05, 1'b1);
		rd(8'h08);
		chk(rsp, 2'h2);
		wr(8'h00, 32'h0d);
		chk(rsp, 2'h0);
		rd(8'h04);
		chk(rd_d[12:8], 5'h1e);
		chk(rd_d[6:0] - 7'h1e < 7'h05, 1'b1);
		wr(8'h04, 32'h0);
		chk(rsp, 2'h0);
		wr(8'h08, 32'h0);
		chk(rsp, 2'h2);
		s_axi_wstrb_i <= 4'he;
		wr(8'h00, 32'h7f);
		s_axi_wstrb_i <= 4'hf;
		rd(8'h00);
		chk(rd_d, 32'h0d);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {i[2:0], 4'h5});
			rd(8'h04);
			chk(rd_d[12], i == 0);
		end
	endtask

	task automatic lat(input logic [31:0] c, input logic tx,
		input int bits);
		int t0;
		int e;
		rst();
		wr(8'h00, c);
		@(negedge lclk);
		sym = 2'h3;
		@(negedge lclk);
		sym = 2'h0;
		t0 = cyc;
		e = bits * 2 * half / 25;
		while ((tx ? tx_positive_out_o : rx_positive_out_o) !== 1'b1
			&& cyc - t0 < 2000)
			@(posedge clk_i);
		chk(cyc - t0 > e - 50 && cyc - t0 < e + 50, 1'b1);
		chk(tx ? tx_negative_out_o : rx_negative_out_o, 1'b1);
		// Smoothed clock tracks the line rate over sixteen bits
		@(posedge (tx ? smoothed_tx_clock_o : smoothed_rx_clock_o));
		t0 = cyc;
		e = 32 * half / 25;
		repeat (16)
			@(posedge (tx ? smoothed_tx_clock_o : smoothed_rx_clock_o));
		chk(cyc - t0 > e - 40 && cyc - t0 < e + 40, 1'b1);
	endtask

	task automatic t_hw();
		@(posedge clk_i);
		mode_select_i <= 1'b0;
		wr(8'h00, 32'h0);
		repeat (4) @(posedge clk_i);
		rd(8'h04);
		chk(rd_d[12:8], 5'h1d);
		line_length_select_i <= 3'h3;
		jitter_path_select_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(8'h04);
		chk(rd_d[12:8], 5'h07);
		line_length_select_i <= 3'h0;
		jitter_path_select_i <= 1'b0;
	endtask

	task automatic drift(input int h, input int f);
		@(posedge clk_i);
		mode_select_i <= 1'b1;
		half = h;
		rst();
		repeat (12000) @(posedge clk_i);
		rd(8'h04);
		chk(|rd_d[f +: 8], 1'b1);
	endtask

	initial begin
		rst();
		run <= 1'b1;
		t_reg();
		lat(32'h0, 1'b0, 16);
		lat(32'h1, 1'b1, 16);
		lat(32'h4, 1'b0, 32);
		t_hw();
		lat(32'h0, 1'b0, 32);
		jitter_path_select_i <= 1'b1;
		lat(32'h0, 1'b1, 32);
		drift(100, 16);
		drift(275, 24);
		final_report();
	end
endmodule // testbench
